// ==== logic/virc_defines.svh ====
// Constants of the vectored interrupt request controller: sizes, offsets, reset values
`ifndef VIRC_DEFINES_SVH
`define VIRC_DEFINES_SVH

// Sizes and the channel that carries external interrupt 3
`define VIRC_NUM_SRC      32
`define VIRC_SRC_IDX_W    5
`define VIRC_PRIO_W       4
`define VIRC_PRIO_ALL_W   128
`define VIRC_NUM_PINS     42
`define VIRC_PIN_HI_W     10
`define VIRC_ADDR_W       8
`define VIRC_DATA_W       32
`define VIRC_EXT3_CHAN    17

// Register byte offsets
`define VIRC_OFS_RAW        8'h00
`define VIRC_OFS_ENABLE     8'h04
`define VIRC_OFS_FAST_SEL   8'h08
`define VIRC_OFS_FAST_STAT  8'h0C
`define VIRC_OFS_NORM_STAT  8'h10
`define VIRC_OFS_VECT_ADDR  8'h14
`define VIRC_OFS_DEF_VECT   8'h18
`define VIRC_OFS_CURRENT    8'h1C
`define VIRC_OFS_PRIO0      8'h20
`define VIRC_OFS_PRIO1      8'h24
`define VIRC_OFS_PRIO2      8'h28
`define VIRC_OFS_PRIO3      8'h2C
`define VIRC_OFS_RISE_LO    8'h30
`define VIRC_OFS_RISE_HI    8'h34
`define VIRC_OFS_FALL_LO    8'h38
`define VIRC_OFS_FALL_HI    8'h3C
`define VIRC_OFS_PSTAT_LO   8'h40
`define VIRC_OFS_PSTAT_HI   8'h44
`define VIRC_VECT_TABLE_BIT 7

// Field positions of the current-source word
`define VIRC_CUR_FAST_BIT   31
`define VIRC_CUR_VALID_BIT  30

// Reset values and the edge detect warm-up count
`define VIRC_RST_WORD       32'h0000_0000
`define VIRC_RST_PRIO       128'h0
`define VIRC_RST_PINS       42'h000_0000_0000
`define VIRC_ARM_COUNT      2'h3

`endif

// ==== logic/virc_pkg.sv ====
// Types shared by the vectored interrupt request controller files
`include "virc_defines.svh"

package virc_pkg;

	// One register-port request, as the bus master drives it
	typedef struct packed {
		logic                      wr;     // Write strobe
		logic                      rd;     // Read strobe
		logic [`VIRC_ADDR_W-1:0]   addr;   // Byte address
		logic [`VIRC_DATA_W-1:0]   wdata;  // Write data
	} virc_bus_req_s;

	// State of the controller top, all but the handler table
	typedef struct packed {
		logic [`VIRC_NUM_SRC-1:0]    enable;    // Per-source enable
		logic [`VIRC_NUM_SRC-1:0]    fast_sel;  // Source classed as fast
		logic [`VIRC_PRIO_ALL_W-1:0] prio;      // Priority nibbles
		logic [`VIRC_DATA_W-1:0]     def_vect;  // Vector when none pending
		logic [`VIRC_NUM_PINS-1:0]   rise_en;   // Rising edge enables
		logic [`VIRC_NUM_PINS-1:0]   fall_en;   // Falling edge enables
		logic [`VIRC_NUM_PINS-1:0]   sync1;     // First synchroniser stage
		logic [`VIRC_NUM_PINS-1:0]   sync2;     // Second synchroniser stage
		logic [`VIRC_NUM_PINS-1:0]   prev;      // Previous synced level
		logic [`VIRC_NUM_PINS-1:0]   pstat;     // Sticky edge flags
		logic [1:0]                  arm_cnt;   // Edge detect warm-up
		logic                        no_win;    // No vectored winner
		logic                        fast_irq;  // Fast request output
		logic                        norm_irq;  // Normal request output
		logic [`VIRC_DATA_W-1:0]     rdata;     // Read data
	} virc_state_s;

endpackage : virc_pkg

// ==== logic/virc_vect_mem.sv ====
// Handler address table with one write port and one registered read port
`timescale 1ns/100ps
`default_nettype none

module virc_vect_mem
#(
	parameter int WIDTH = 32,  // Word width
	parameter int DEPTH = 32,  // Number of entries
	parameter int AW    = 5    // Address width
)
(
	input  wire logic             clk_in,      // System clock
	input  wire logic             reset_in,    // Sync reset, high
	input  wire logic             wr_en_in,    // Write enable
	input  wire logic [AW-1:0]    wr_addr_in,  // Write entry
	input  wire logic [WIDTH-1:0] wr_data_in,  // Write word
	input  wire logic [AW-1:0]    rd_addr_in,  // Read entry
	output logic      [WIDTH-1:0] rd_data_out  // Registered read word
);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
	logic [WIDTH-1:0] rd_q;           // Read register

	// Cleared on reset so an unprogrammed vector reads as zero
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			for (int k = 0; k < DEPTH; k++)
				mem_q[k] <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (wr_en_in)
				mem_q[wr_addr_in] <= wr_data_in;
			rd_q <= mem_q[rd_addr_in];
		end
	end

	assign rd_data_out = rd_q;

endmodule // virc_vect_mem

`default_nettype wire

// ==== logic/virc_top.sv ====
// Vectored interrupt request controller with port pin edge interrupts
`timescale 1ns/100ps
`default_nettype none
`include "virc_defines.svh"

// How it works
// - Fast class outranks every vectored request
// - Fast sources ORed into one output
// - Readable word shows asserting fast sources
// - Other sources vectored, with programmable priority
// - Equal priority ties go to lowest channel
// - Normal output is OR of vectored requests
// - Register supplies selected source's handler address
// - One request line per peripheral channel
// - Pins interrupt on rise, fall or both
// - Pin edge flags ORed into external interrupt 3
module virc_top
	import virc_pkg::*;
(
	input  wire logic                       clk_in,         // System clock, 25 MHz
	input  wire logic                       reset_in,       // Sync reset, high
	input  wire virc_bus_req_s              bus_in,         // Register port request
	output logic      [`VIRC_DATA_W-1:0]    rd_data_out,    // Read data, next cycle
	input  wire logic [`VIRC_NUM_SRC-1:0]   src_req_in,     // Peripheral request lines
	input  wire logic [`VIRC_NUM_PINS-1:0]  port_pins_in,   // Port 0 and 2 pin levels
	output logic                            fast_irq_out,   // Fast request to core
	output logic                            normal_irq_out  // Normal request to core
);

	localparam int NSRC = `VIRC_NUM_SRC;   // Channels
	localparam int NPIN = `VIRC_NUM_PINS;  // Edge pins
	localparam int PW   = `VIRC_PRIO_W;    // Priority width
	localparam int IW   = `VIRC_SRC_IDX_W; // Channel index width
	localparam int HW   = `VIRC_PIN_HI_W;  // Pins in the high word

	virc_state_s             st_q;          // Registered state
	virc_state_s             st_d;          // Next state
	logic [NSRC-1:0]         raw_req;       // Lines after pin merge
	logic [NSRC-1:0]         fast_req;      // Enabled fast requests
	logic [NSRC-1:0]         norm_req;      // Enabled vectored requests
	logic [NPIN-1:0]         pin_set;       // Edge seen this cycle
	logic                    pin_any;       // Any sticky pin flag
	logic                    win_v [NSRC+1];// Chain: winner valid
	logic [PW-1:0]           win_p [NSRC+1];// Chain: winner priority
	logic [IW-1:0]           win_i [NSRC+1];// Chain: winner index
	logic [`VIRC_DATA_W-1:0] mem_rdata;     // Vector of last winner
	logic                    vect_wr;       // Table write
	logic [`VIRC_DATA_W-1:0] vect_word;     // Vector address readout
	logic [`VIRC_DATA_W-1:0] cur_word;      // Current source readout

	// One request bit per channel; all pin edge flags are ORed into channel 17's bit here
	assign pin_any = |st_q.pstat;
	always_comb
	begin
		raw_req = src_req_in;
		raw_req[`VIRC_EXT3_CHAN] = src_req_in[`VIRC_EXT3_CHAN] | pin_any;
	end

	// Class split: a set select bit makes a source fast
	assign fast_req = raw_req & st_q.enable & st_q.fast_sel;
	assign norm_req = raw_req & st_q.enable & ~st_q.fast_sel;

	// Per-pin edge detect on the synced level
	generate
		for (genvar p = 0; p < NPIN; p++)
		begin : g_pin
			logic rise; // Low to high
			logic fall; // High to low
			assign rise = st_q.sync2[p] & ~st_q.prev[p];
			assign fall = ~st_q.sync2[p] & st_q.prev[p];
			// Ignored until the synchroniser holds real samples
			assign pin_set[p] = (st_q.arm_cnt == `VIRC_ARM_COUNT) &
				((rise & st_q.rise_en[p]) | (fall & st_q.fall_en[p]));
		end
	endgenerate

	// Priority chain from the top channel down; lower value is more urgent
	assign win_v[NSRC] = 1'b0;
	assign win_p[NSRC] = '0;
	assign win_i[NSRC] = '0;
	generate
		for (genvar c = NSRC - 1; c >= 0; c--)
		begin : g_arb
			logic          take; // This channel beats the rest above
			logic [PW-1:0] cp;   // This channel's priority
			assign cp = st_q.prio[c*PW +: PW];
			// Less-or-equal lets the lower channel win a tie
			assign take = norm_req[c] & (~win_v[c+1] | (cp <= win_p[c+1]));
			assign win_v[c] = take | win_v[c+1];
			assign win_p[c] = take ? cp : win_p[c+1];
			assign win_i[c] = take ? IW'(c) : win_i[c+1];
		end
	endgenerate

	// Table writes land in the upper half of the address space
	assign vect_wr = bus_in.wr & bus_in.addr[`VIRC_VECT_TABLE_BIT];

	virc_vect_mem
	#(
		.WIDTH (`VIRC_DATA_W),
		.DEPTH (NSRC),
		.AW    (IW)
	)
	u_vect_mem
	(
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.wr_en_in    (vect_wr),
		.wr_addr_in  (bus_in.addr[IW+1:2]),
		.wr_data_in  (bus_in.wdata),
		.rd_addr_in  (win_i[0]),
		.rd_data_out (mem_rdata)
	);

	// Handler address of the winner, or the default when none pends
	assign vect_word = st_q.no_win ? st_q.def_vect : mem_rdata;

	// Fast class takes the current slot over any vectored winner
	always_comb
	begin
		cur_word = '0;
		cur_word[`VIRC_CUR_FAST_BIT] = |fast_req;
		cur_word[`VIRC_CUR_VALID_BIT] = win_v[0] & ~(|fast_req);
		cur_word[IW-1:0] = win_i[0];
	end

	// Next state: register writes, pin sampling, outputs, read data
	always_comb
	begin
		st_d = st_q;

		// Register writes; unmapped offsets are ignored
		if (bus_in.wr & ~bus_in.addr[`VIRC_VECT_TABLE_BIT])
		begin
			case (bus_in.addr)
				`VIRC_OFS_ENABLE:   st_d.enable = bus_in.wdata;
				`VIRC_OFS_FAST_SEL: st_d.fast_sel = bus_in.wdata;
				`VIRC_OFS_DEF_VECT: st_d.def_vect = bus_in.wdata;
				`VIRC_OFS_PRIO0:    st_d.prio[0*32 +: 32] = bus_in.wdata;
				`VIRC_OFS_PRIO1:    st_d.prio[1*32 +: 32] = bus_in.wdata;
				`VIRC_OFS_PRIO2:    st_d.prio[2*32 +: 32] = bus_in.wdata;
				`VIRC_OFS_PRIO3:    st_d.prio[3*32 +: 32] = bus_in.wdata;
				`VIRC_OFS_RISE_LO:  st_d.rise_en[31:0] = bus_in.wdata;
				`VIRC_OFS_RISE_HI:  st_d.rise_en[NPIN-1:32] = bus_in.wdata[HW-1:0];
				`VIRC_OFS_FALL_LO:  st_d.fall_en[31:0] = bus_in.wdata;
				`VIRC_OFS_FALL_HI:  st_d.fall_en[NPIN-1:32] = bus_in.wdata[HW-1:0];
				`VIRC_OFS_PSTAT_LO: st_d.pstat[31:0] = st_q.pstat[31:0] & ~bus_in.wdata;
				`VIRC_OFS_PSTAT_HI:
				begin
					st_d.pstat[NPIN-1:32] = st_q.pstat[NPIN-1:32] & ~bus_in.wdata[HW-1:0];
				end
				default:            st_d.enable = st_q.enable;
			endcase
		end

		// A new edge beats a clear in the same cycle
		st_d.pstat = st_d.pstat | pin_set;

		// Two-stage synchroniser, then the edge reference
		st_d.sync1 = port_pins_in;
		st_d.sync2 = st_q.sync1;
		st_d.prev = st_q.sync2;
		if (st_q.arm_cnt != `VIRC_ARM_COUNT)
			st_d.arm_cnt = st_q.arm_cnt + 2'h1;

		// Core outputs, one flop after the request lines
		st_d.fast_irq = |fast_req;
		st_d.norm_irq = |norm_req;
		st_d.no_win = ~win_v[0];

		// Read data stand only in the cycle after the strobe
		st_d.rdata = '0;
		if (bus_in.rd)
		begin
			case (bus_in.addr)
				`VIRC_OFS_RAW:       st_d.rdata = raw_req;
				`VIRC_OFS_ENABLE:    st_d.rdata = st_q.enable;
				`VIRC_OFS_FAST_SEL:  st_d.rdata = st_q.fast_sel;
				`VIRC_OFS_FAST_STAT: st_d.rdata = fast_req;
				`VIRC_OFS_NORM_STAT: st_d.rdata = norm_req;
				`VIRC_OFS_VECT_ADDR: st_d.rdata = vect_word;
				`VIRC_OFS_DEF_VECT:  st_d.rdata = st_q.def_vect;
				`VIRC_OFS_CURRENT:   st_d.rdata = cur_word;
				`VIRC_OFS_PRIO0:     st_d.rdata = st_q.prio[0*32 +: 32];
				`VIRC_OFS_PRIO1:     st_d.rdata = st_q.prio[1*32 +: 32];
				`VIRC_OFS_PRIO2:     st_d.rdata = st_q.prio[2*32 +: 32];
				`VIRC_OFS_PRIO3:     st_d.rdata = st_q.prio[3*32 +: 32];
				`VIRC_OFS_RISE_LO:   st_d.rdata = st_q.rise_en[31:0];
				`VIRC_OFS_RISE_HI:   st_d.rdata = {{(32-HW){1'b0}}, st_q.rise_en[NPIN-1:32]};
				`VIRC_OFS_FALL_LO:   st_d.rdata = st_q.fall_en[31:0];
				`VIRC_OFS_FALL_HI:   st_d.rdata = {{(32-HW){1'b0}}, st_q.fall_en[NPIN-1:32]};
				`VIRC_OFS_PSTAT_LO:  st_d.rdata = st_q.pstat[31:0];
				`VIRC_OFS_PSTAT_HI:  st_d.rdata = {{(32-HW){1'b0}}, st_q.pstat[NPIN-1:32]};
				// Unmapped offsets and the write-only table read as zero
				default:             st_d.rdata = '0;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			st_q.enable   <= `VIRC_RST_WORD;
			st_q.fast_sel <= `VIRC_RST_WORD;
			st_q.prio     <= `VIRC_RST_PRIO;
			st_q.def_vect <= `VIRC_RST_WORD;
			st_q.rise_en  <= `VIRC_RST_PINS;
			st_q.fall_en  <= `VIRC_RST_PINS;
			st_q.sync1    <= `VIRC_RST_PINS;
			st_q.sync2    <= `VIRC_RST_PINS;
			st_q.prev     <= `VIRC_RST_PINS;
			st_q.pstat    <= `VIRC_RST_PINS;
			st_q.arm_cnt  <= 2'h0;
			st_q.no_win   <= 1'b1;
			st_q.fast_irq <= 1'b0;
			st_q.norm_irq <= 1'b0;
			st_q.rdata    <= `VIRC_RST_WORD;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state flops
	assign rd_data_out    = st_q.rdata;
	assign fast_irq_out   = st_q.fast_irq;
	assign normal_irq_out = st_q.norm_irq;

endmodule // virc_top

`default_nettype wire

// ==== verification/virc_periph.sv ====
// Peripheral request lines seen by the controller, answering promptly or late
`timescale 1ns/100ps
`default_nettype none
`include "virc_defines.svh"

module virc_periph
	import virc_pkg::*;
(
	input  wire logic                     clk_in,      // System clock
	input  wire logic                     reset_in,    // Sync reset, high
	input  wire logic [3:0]               lag_in,      // Cycles before a request shows
	input  wire logic [`VIRC_NUM_SRC-1:0] want_in,     // Requests the bench asks for
	output logic      [`VIRC_NUM_SRC-1:0] src_req_out  // One level line per peripheral
);
	logic [15:0][`VIRC_NUM_SRC-1:0] pipe_q;  // Delay line of asked requests

	// Delay line models a peripheral slow to flag its event
	always_ff @(posedge clk_in)
		if (reset_in)
			pipe_q <= '0;
		else
			pipe_q <= {pipe_q[14:0], want_in};

	// Lag zero answers at once, else from the delay line
	assign src_req_out = (lag_in == 4'h0) ? want_in : pipe_q[lag_in - 4'h1];
endmodule // virc_periph
`default_nettype wire

// ==== verification/virc_asserts.sv ====
// Checker on the controller ports, bound into the top
`timescale 1ns/100ps
`default_nettype none
`include "virc_defines.svh"

module virc_asserts
	import virc_pkg::*;
(
	input  wire logic                      clk_in,         // System clock
	input  wire logic                      reset_in,       // Sync reset, high
	input  wire virc_bus_req_s             bus_in,         // Register port request
	input  wire logic [`VIRC_DATA_W-1:0]   rd_data_out,    // Read data
	input  wire logic [`VIRC_NUM_SRC-1:0]  src_req_in,     // Request lines
	input  wire logic [`VIRC_NUM_PINS-1:0] port_pins_in,   // Pin levels
	input  wire logic                      fast_irq_out,   // Fast request
	input  wire logic                      normal_irq_out  // Normal request
);
	logic [31:0] en_q;   // Shadow of the enable register
	logic [31:0] sel_q;  // Shadow of the fast class register
	// Pin merge on channel 17 is invisible here, so checks wait while it is on
	wire logic        quiet  = !en_q[`VIRC_EXT3_CHAN];
	wire logic [31:0] fast_w = src_req_in & en_q & sel_q;   // Live fast sources
	wire logic [31:0] norm_w = src_req_in & en_q & ~sel_q;  // Live vectored sources
	wire logic        rd_cur = bus_in.rd && bus_in.addr == `VIRC_OFS_CURRENT;

	// Snoop enable writes
	always_ff @(posedge clk_in)
		if (reset_in)
			en_q <= '0;
		else if (bus_in.wr && bus_in.addr == `VIRC_OFS_ENABLE)
			en_q <= bus_in.wdata;

	// Snoop class writes
	always_ff @(posedge clk_in)
		if (reset_in)
			sel_q <= '0;
		else if (bus_in.wr && bus_in.addr == `VIRC_OFS_FAST_SEL)
			sel_q <= bus_in.wdata;

	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_fast_or_out: assert property ($past(quiet) |-> fast_irq_out == $past(|fast_w))
		else $error("fast output differs from OR of fast sources");
	a_norm_or_out: assert property (quiet |=> normal_irq_out == $past(|norm_w))
		else $error("normal output differs from OR of vectored sources");
	a_rd_idle_zero: assert property (!bus_in.rd |=> rd_data_out == '0)
		else $error("read data not zero outside read answer");
	a_fast_word: assert property (bus_in.rd && bus_in.addr == `VIRC_OFS_FAST_STAT && quiet
		|=> rd_data_out == $past(fast_w)) else $error("fast status word wrong");
	a_norm_word: assert property (bus_in.rd && bus_in.addr == `VIRC_OFS_NORM_STAT && quiet
		|=> rd_data_out == $past(norm_w)) else $error("vectored status word wrong");
	a_raw_lines: assert property (bus_in.rd && bus_in.addr == `VIRC_OFS_RAW
		|=> (rd_data_out & 32'hFFFD_FFFF) == $past(src_req_in & 32'hFFFD_FFFF))
		else $error("raw request word wrong");
	a_fast_precede: assert property (rd_cur && quiet && |fast_w
		|=> rd_data_out[31:30] == 2'b10) else $error("fast class not ahead of vectored");
	a_vect_valid: assert property (rd_cur && quiet && !(|fast_w) && |norm_w
		|=> rd_data_out[31:30] == 2'b01) else $error("vectored winner not flagged");

	c_both_out: cover property (fast_irq_out && normal_irq_out);
	c_cur_fast: cover property (rd_cur && |fast_w);
	c_pin_merge: cover property (normal_irq_out && !quiet);
endmodule // virc_asserts

bind virc_top virc_asserts virc_asserts_inst
(
	.clk_in         (clk_in),
	.reset_in       (reset_in),
	.bus_in         (bus_in),
	.rd_data_out    (rd_data_out),
	.src_req_in     (src_req_in),
	.port_pins_in   (port_pins_in),
	.fast_irq_out   (fast_irq_out),
	.normal_irq_out (normal_irq_out)
);
`default_nettype wire

// ==== verification/virc_top_tb.sv ====
// Self-checking bench for the vectored interrupt request controller
`timescale 1ns/100ps
`default_nettype none
`include "virc_defines.svh"

module virc_top_tb
	import virc_pkg::*;
;
	logic          clk_in   = 1'b0;  // System clock
	logic          reset_in = 1'b1;  // Sync reset
	virc_bus_req_s bus      = '0;    // Register port request
	logic [31:0]   rd_data_out;      // Read data
	logic [31:0]   src_req;          // Partner request lines
	logic [31:0]   want     = '0;    // Requests to raise
	logic [3:0]    lag      = 4'h0;  // Partner delay
	logic [41:0]   pins     = '0;    // Port pin levels
	logic          fast_irq_out;     // Fast request
	logic          normal_irq_out;   // Normal request
	logic [31:0]   got;              // Last read word
	logic [7:0]    ofs;              // Pin status offset
	logic [31:0]   bitw;             // Expected pin flag word
	int            n_mismatch = 0;   // Mismatches
	int            checks     = 0;   // Comparisons
	logic [7:0]    rw_ofs [11] = '{8'h04, 8'h08, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C,
		8'h30, 8'h34, 8'h38, 8'h3C};  // Writable registers
	int            pin_i [7] = '{0, 0, 5, 41, 41, 33, 33};  // Pin stepped
	logic          pin_v [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};  // New level
	logic          pin_f [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};  // Flag expected

	// 25 MHz clock
	always #20 clk_in = ~clk_in;

	virc_top virc_top_inst (.clk_in(clk_in), .reset_in(reset_in), .bus_in(bus),
		.rd_data_out(rd_data_out), .src_req_in(src_req), .port_pins_in(pins),
		.fast_irq_out(fast_irq_out), .normal_irq_out(normal_irq_out));
	virc_periph virc_periph_inst (.clk_in(clk_in), .reset_in(reset_in), .lag_in(lag),
		.want_in(want), .src_req_out(src_req));

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic do_reset();
		reset_in <= 1'b1;
		tick(8);
		reset_in <= 1'b0;
		tick(1);
	endtask

	// Each access leaves one idle cycle so no strobe is driven twice at one edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		bus <= '0;
		tick(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		tick(1);
		bus <= '0;
		@(negedge clk_in);
		d = rd_data_out;
		tick(1);
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, got);
		chk($sformatf("reg_%h", a), got, e);
	endtask

	// Outputs looked at mid-cycle, away from the edge that launches them
	task automatic irqchk(input logic f, input logic n);
		@(negedge clk_in);
		chk("fast_irq", {31'h0, fast_irq_out}, {31'h0, f});
		chk("normal_irq", {31'h0, normal_irq_out}, {31'h0, n});
		tick(1);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog against a hung sequence
	initial
	begin
		tick(20000);
		n_mismatch++;
		tally_and_finish();
	end

	initial
	begin
		do_reset();
		// Reset values, write then read back, unmapped places answer zero
		foreach (rw_ofs[i])
		begin
			rdchk(rw_ofs[i], 32'h0);
			wr(rw_ofs[i], 32'hA5A5_5A5A);
			rdchk(rw_ofs[i], rw_ofs[i] inside {8'h34, 8'h3C} ? 32'h25A : 32'hA5A5_5A5A);
			wr(rw_ofs[i], 32'h0);
		end
		wr(8'h50, 32'hFFFF_FFFF);
		rdchk(8'h50, 32'h0);
		rdchk(8'h80, 32'h0);
		// Handler table, all but channel 17 enabled, three vectored requests
		for (int n = 0; n < 32; n++)
			wr(8'h80 + 8'(4 * n), 32'h1000 + n);
		wr(8'h04, 32'hFFFD_FFFF);
		want <= 32'h0000_0608;
		tick(3);
		irqchk(1'b0, 1'b1);
		rdchk(8'h1C, 32'h4000_0003);
		rdchk(8'h14, 32'h0000_1003);
		wr(8'h20, 32'h0000_5000);  // Channel 3 demoted, 9 and 10 tie
		tick(2);
		rdchk(8'h1C, 32'h4000_0009);
		rdchk(8'h14, 32'h0000_1009);
		// Channels 9 and 20 fast: out of arbitration, ahead of vectored
		wr(8'h08, 32'h0010_0200);
		want <= 32'h0010_0608;
		tick(3);
		irqchk(1'b1, 1'b1);
		rdchk(8'h0C, 32'h0010_0200);
		rdchk(8'h10, 32'h0000_0408);
		rd(8'h1C, got);
		chk("current_top", {30'h0, got[31:30]}, 32'h2);
		rdchk(8'h14, 32'h0000_100A);
		want <= 32'h0010_0000;
		tick(3);
		irqchk(1'b1, 1'b0);
		wr(8'h18, 32'hDEF0_0000);
		want <= 32'h0;
		tick(3);
		irqchk(1'b0, 1'b0);
		rdchk(8'h14, 32'hDEF0_0000);
		// Slow peripheral: line shows 9 cycles late, output one flop after that
		lag <= 4'h9;
		want <= 32'h0000_0020;
		tick(4);
		irqchk(1'b0, 1'b0);
		tick(4);
		irqchk(1'b0, 1'b0);
		irqchk(1'b0, 1'b1);
		lag <= 4'h0;
		want <= 32'h0;
		// Edge enables set before channel 17 is switched on
		wr(8'h08, 32'h0);
		wr(8'h30, 32'h1);
		wr(8'h34, 32'h2);
		wr(8'h3C, 32'h202);
		wr(8'h04, 32'h0002_0000);
		foreach (pin_i[i])
		begin
			pins[pin_i[i]] <= pin_v[i];
			tick(6);
			ofs = pin_i[i] >= 32 ? 8'h44 : 8'h40;
			bitw = pin_f[i] ? 32'h1 << (pin_i[i] % 32) : 32'h0;
			rdchk(ofs, bitw);
			rdchk(8'h00, {14'h0, pin_f[i], 17'h0});
			irqchk(1'b0, pin_f[i]);
			wr(ofs, bitw);
			tick(2);
			rdchk(ofs, 32'h0);
			irqchk(1'b0, 1'b0);
		end
		// Reset in mid-run clears the registers
		wr(8'h04, 32'hFFFF_FFFF);
		do_reset();
		rdchk(8'h04, 32'h0);
		irqchk(1'b0, 1'b0);
		tally_and_finish();
	end
endmodule // virc_top_tb
`default_nettype wire
